/* File: rtl/cssc_map.svh */
// Purpose: Offsets, field positions, reset values and widths of the sense control block
// Assumes: Byte addresses on an 8-bit register port with 32-bit data
// Notes:   Definitions only
`ifndef CSSC_MAP_SVH
`define CSSC_MAP_SVH

// ------------------------------------------------------------------
// Widths
// ------------------------------------------------------------------
`define CSSC_AW            8
`define CSSC_DW            32
`define CSSC_SW            10
`define CSSC_OW            6
`define CSSC_IRQW          3

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define CSSC_GENERAL_CONFIG_REGISTER   8'h00
`define CSSC_RETRY_CONFIG_REGISTER0    8'h04
`define CSSC_RETRY_CONFIG_REGISTER1    8'h08
`define CSSC_FAULT_REPORT_REGISTER     8'h0c
`define CSSC_STATUS_REPORT_REGISTER    8'h10
`define CSSC_IRQ_STATUS_REGISTER       8'h14
`define CSSC_IRQ_MASK_REGISTER         8'h18

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define CSSC_SENSE_SELECT_BIT0         0
`define CSSC_SENSE_SELECT_BIT1         1
`define CSSC_TRACK_HOLD_BIT            3
`define CSSC_OFFSET_POLARITY_BIT       8
`define CSSC_PREWARN_BIT               8
`define CSSC_STATE_CH0_BIT             0
`define CSSC_STATE_CH1_BIT             1
`define CSSC_IRQ_PREWARN               0
`define CSSC_IRQ_HELD                  1
`define CSSC_IRQ_VALID                 2

// ------------------------------------------------------------------
// Encodings and reset values
// ------------------------------------------------------------------
`define CSSC_SEL_CH0                   2'h0
`define CSSC_SEL_CH1                   2'h1
`define CSSC_TRACK_HOLD_RESET          1'h0
`define CSSC_SENSE_SEL_RESET           2'h0
`define CSSC_OFFSET_POS_RESET          2'h0
`define CSSC_IRQ_MASK_RESET            3'h0
`define CSSC_SENSE_ZERO                10'h000
`define CSSC_SENSE_MAX                 10'h3ff

`endif

/* File: rtl/cssc_pkg.sv */
// Purpose: Types shared by the sense control block
// Assumes: cssc_map.svh supplies the widths
// Notes:   Each module keeps all of its state in one packed struct
`include "cssc_map.svh"

package cssc_pkg;

    // ------------------------------------------------------------------
    // Sensing sequence of the selected channel
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CSSC_OFF   = 2'b00,
        CSSC_VALID = 2'b01,
        CSSC_CLEAR = 2'b10
    } cssc_mode_t;

    // ------------------------------------------------------------------
    // Pin bundle, synchronised as one group
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]             chanOn;
        logic [1:0]             settled;
        logic [1:0]             outHigh;
        logic                   blank;
        logic                   tempHigh;
        logic [`CSSC_SW-1:0]    load0;
        logic [`CSSC_SW-1:0]    load1;
        logic [`CSSC_SW-1:0]    temp;
        logic [`CSSC_OW-1:0]    offset;
    } cssc_pins_t;

    typedef struct packed {
        logic                   trackHold;
        logic [1:0]             senseSel;
        logic [1:0]             offsetPos;
    } cssc_cfg_t;

    typedef struct packed {
        cssc_pins_t             pinMeta;
        cssc_pins_t             pinSync;
        cssc_cfg_t              cfg;
        cssc_mode_t             mode;
        logic [1:0]             prevSel;
        logic                   prevTemp;
        logic [`CSSC_SW-1:0]    lastLive;
        logic                   capture;
        logic                   clear;
        logic                   prewarn;
        logic [`CSSC_IRQW-1:0]  irqStatus;
        logic [`CSSC_IRQW-1:0]  irqMask;
        logic [`CSSC_SW-1:0]    senseOut;
        logic                   strobeN;
        logic                   irq;
        logic [`CSSC_DW-1:0]    rdData;
    } cssc_state_t;

    typedef struct packed {
        logic [`CSSC_SW-1:0]    held;
    } cssc_hold_state_t;

endpackage

/* File: rtl/cssc_hold.sv */
// Purpose: Sample store that keeps the sense value taken at switch-off
// Assumes: capture and clear are one-cycle pulses from the same clock, never together
// Notes:   Clear has priority so a stale sample never survives a channel change
`timescale 1ns/1ps
`include "cssc_map.svh"

module cssc_hold (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [`CSSC_SW-1:0]    live,
    input  wire logic                   capture,
    input  wire logic                   clear,
    output logic      [`CSSC_SW-1:0]    held
);

    cssc_pkg::cssc_hold_state_t r;
    cssc_pkg::cssc_hold_state_t next_r;

    always_comb begin
        next_r = r;
        if (clear) begin
            next_r.held = `CSSC_SENSE_ZERO;
        end else if (capture) begin
            next_r.held = live;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r.held <= `CSSC_SENSE_ZERO;
        end else begin
            r <= next_r;
        end
    end

    assign held = r.held;

endmodule

/* File: rtl/cssc_top.sv */
// Purpose: Current sense output control, sense-valid strobe and status indications
// Assumes: Analog quantities arrive as digital codes; all pins are asynchronous
// Notes:   Sense output is a code standing for the analog sense current
//
// How it works
// - Sync sensing while track-and-hold enable is 0; it resets to 0.
// - Strobe goes low once on and settled, stays low until switch-off, blanking or a select change.
// - Sync mode presents no channel current once the channel is off.
// - Track-and-hold samples the last sense value at switch-off and presents it.
// - Track-and-hold drives the strobe high at the switch-off sample instant.
// - Selected channel change empties the held sample before acquiring the new one.
// - Per-channel polarity bit D8 picks sign of random offset, 1 positive.
// - Held sample keeps the polarity active at switch-off; later changes ignored.
// - Prewarning flag OD8 sets above threshold; the channel keeps running.
// - Prewarning flag clears only on fault read below threshold.
// - Bits OD0 and OD1 show each output above half supply, live.
// - Reported state may differ from drive command at low supply.
// - Blanking windows disable sensing and hold the strobe high.
// - Select bits choose channel 0 current, channel 1 current or temperature.
`timescale 1ns/1ps
`include "cssc_map.svh"

module cssc_top (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [`CSSC_AW-1:0]    addr,
    input  wire logic [`CSSC_DW-1:0]    wrData,
    input  wire logic                   wrStrobe,
    input  wire logic                   rdStrobe,
    output logic      [`CSSC_DW-1:0]    rdData,
    input  wire logic [1:0]             chanOn,
    input  wire logic [1:0]             senseSettled,
    input  wire logic [1:0]             outAboveHalf,
    input  wire logic                   blankActive,
    input  wire logic                   tempAbovePrewarn,
    input  wire logic [`CSSC_SW-1:0]    loadCode0,
    input  wire logic [`CSSC_SW-1:0]    loadCode1,
    input  wire logic [`CSSC_SW-1:0]    tempCode,
    input  wire logic [`CSSC_OW-1:0]    offsetCode,
    output logic      [`CSSC_SW-1:0]    senseOut,
    output logic                        sense_valid_strobe_n,
    output logic                        irq
);

    cssc_pkg::cssc_state_t r;
    cssc_pkg::cssc_state_t next_r;
    cssc_pkg::cssc_pins_t  pinsIn;
    logic [`CSSC_SW-1:0]   held;

    // ------------------------------------------------------------------
    // Pin bundle
    // ------------------------------------------------------------------
    // Grouped so one two-stage synchroniser covers every pin
    always_comb begin
        pinsIn.chanOn   = chanOn;
        pinsIn.settled  = senseSettled;
        pinsIn.outHigh  = outAboveHalf;
        pinsIn.blank    = blankActive;
        pinsIn.tempHigh = tempAbovePrewarn;
        pinsIn.load0    = loadCode0;
        pinsIn.load1    = loadCode1;
        pinsIn.temp     = tempCode;
        pinsIn.offset   = offsetCode;
    end

    // ------------------------------------------------------------------
    // Held sample store
    // ------------------------------------------------------------------
    // Kept apart so clear-over-capture priority lives in one place
    cssc_hold u_hold (
        .clk     (clk),
        .rst_n   (rst_n),
        .live    (r.lastLive),
        .capture (r.capture),
        .clear   (r.clear),
        .held    (held)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic                   selTemp;
    logic                   selCh;
    logic                   chOn;
    logic                   chSettled;
    logic                   polPos;
    logic [`CSSC_SW-1:0]    loadSel;
    logic [`CSSC_SW:0]      sumUp;
    logic [`CSSC_SW:0]      sumDown;
    logic [`CSSC_SW-1:0]    live;
    logic                   faultRead;
    logic                   irqRead;
    logic [`CSSC_IRQW-1:0]  events;

    always_comb begin
        next_r = r;
        next_r.capture = 1'b0;
        next_r.clear   = 1'b0;

        // Double registering; multi-bit codes are assumed to change slowly
        next_r.pinMeta = pinsIn;
        next_r.pinSync = r.pinMeta;

        // Source selection from the latched configuration
        selTemp   = (r.cfg.senseSel != `CSSC_SEL_CH0) &&
                    (r.cfg.senseSel != `CSSC_SEL_CH1);
        selCh     = (r.cfg.senseSel == `CSSC_SEL_CH1);
        chOn      = r.pinSync.chanOn[selCh];
        chSettled = r.pinSync.settled[selCh];
        polPos    = r.cfg.offsetPos[selCh];
        loadSel   = selCh ? r.pinSync.load1 : r.pinSync.load0;

        // Random offset added with the chosen sign, clipped at the code range
        sumUp   = {1'b0, loadSel} + {{(`CSSC_SW+1-`CSSC_OW){1'b0}}, r.pinSync.offset};
        sumDown = {1'b0, loadSel} - {{(`CSSC_SW+1-`CSSC_OW){1'b0}}, r.pinSync.offset};
        if (polPos) begin
            live = sumUp[`CSSC_SW] ? `CSSC_SENSE_MAX : sumUp[`CSSC_SW-1:0];
        end else begin
            live = sumDown[`CSSC_SW] ? `CSSC_SENSE_ZERO : sumDown[`CSSC_SW-1:0];
        end

        events = '0;

        // Sensing sequence
        if (selTemp) begin
            next_r.mode     = cssc_pkg::CSSC_OFF;
            next_r.senseOut = r.pinSync.temp;
            next_r.strobeN  = 1'b1;
        end else if ((r.prevSel != r.cfg.senseSel) || r.prevTemp) begin
            // New channel: drop whatever was held before acquiring it
            next_r.mode     = cssc_pkg::CSSC_CLEAR;
            next_r.clear    = 1'b1;
            next_r.senseOut = `CSSC_SENSE_ZERO;
            next_r.strobeN  = 1'b1;
        end else begin
            unique case (r.mode)
                cssc_pkg::CSSC_OFF: begin
                    next_r.strobeN  = 1'b1;
                    // Off: zero in sync mode, held sample in track-and-hold
                    // Store loads one edge after capture; bridge that edge
                    if (r.capture) begin
                        next_r.senseOut = r.lastLive;
                    end else begin
                        next_r.senseOut = r.cfg.trackHold ? held
                                                          : `CSSC_SENSE_ZERO;
                    end
                    if (chOn && chSettled && !r.pinSync.blank) begin
                        next_r.mode     = cssc_pkg::CSSC_VALID;
                        next_r.strobeN  = 1'b0;
                        next_r.senseOut = live;
                        next_r.lastLive = live;
                        events[`CSSC_IRQ_VALID] = 1'b1;
                    end
                end
                cssc_pkg::CSSC_VALID: begin
                    if (r.pinSync.blank) begin
                        // Sensing is meaningless while blanking runs
                        next_r.mode     = cssc_pkg::CSSC_OFF;
                        next_r.strobeN  = 1'b1;
                        next_r.senseOut = r.cfg.trackHold ? held
                                                          : `CSSC_SENSE_ZERO;
                    end else if (!chOn) begin
                        next_r.mode    = cssc_pkg::CSSC_OFF;
                        next_r.strobeN = 1'b1;
                        if (r.cfg.trackHold) begin
                            // Sample uses the value and polarity seen while on
                            next_r.capture  = 1'b1;
                            next_r.senseOut = r.lastLive;
                            events[`CSSC_IRQ_HELD] = 1'b1;
                        end else begin
                            next_r.senseOut = `CSSC_SENSE_ZERO;
                        end
                    end else begin
                        next_r.strobeN  = 1'b0;
                        next_r.senseOut = live;
                        next_r.lastLive = live;
                    end
                end
                cssc_pkg::CSSC_CLEAR: begin
                    next_r.mode     = cssc_pkg::CSSC_OFF;
                    next_r.strobeN  = 1'b1;
                    next_r.senseOut = `CSSC_SENSE_ZERO;
                end
                default: begin
                    next_r.mode     = cssc_pkg::CSSC_OFF;
                    next_r.strobeN  = 1'b1;
                    next_r.senseOut = `CSSC_SENSE_ZERO;
                end
            endcase
        end
        next_r.prevSel  = r.cfg.senseSel;
        next_r.prevTemp = selTemp;

        // Prewarning: set wins over the read-clear; output is never touched
        faultRead = rdStrobe && (addr == `CSSC_FAULT_REPORT_REGISTER);
        if (r.pinSync.tempHigh) begin
            next_r.prewarn = 1'b1;
            if (!r.prewarn) begin
                events[`CSSC_IRQ_PREWARN] = 1'b1;
            end
        end else if (faultRead) begin
            next_r.prewarn = 1'b0;
        end

        // Sticky interrupt status, cleared by reading it
        irqRead = rdStrobe && (addr == `CSSC_IRQ_STATUS_REGISTER);
        next_r.irqStatus = (irqRead ? '0 : r.irqStatus) | events;

        // Configuration writes latch only on a decoded address
        if (wrStrobe) begin
            unique case (addr)
                `CSSC_GENERAL_CONFIG_REGISTER: begin
                    next_r.cfg.trackHold   = wrData[`CSSC_TRACK_HOLD_BIT];
                    next_r.cfg.senseSel[0] = wrData[`CSSC_SENSE_SELECT_BIT0];
                    next_r.cfg.senseSel[1] = wrData[`CSSC_SENSE_SELECT_BIT1];
                end
                `CSSC_RETRY_CONFIG_REGISTER0: begin
                    next_r.cfg.offsetPos[0] = wrData[`CSSC_OFFSET_POLARITY_BIT];
                end
                `CSSC_RETRY_CONFIG_REGISTER1: begin
                    next_r.cfg.offsetPos[1] = wrData[`CSSC_OFFSET_POLARITY_BIT];
                end
                `CSSC_IRQ_MASK_REGISTER: begin
                    next_r.irqMask = wrData[`CSSC_IRQW-1:0];
                end
                default: begin
                    next_r.irqMask = r.irqMask;
                end
            endcase
        end

        // Read data for exactly one cycle; unmapped reads give zero
        next_r.rdData = '0;
        if (rdStrobe) begin
            unique case (addr)
                `CSSC_GENERAL_CONFIG_REGISTER: begin
                    next_r.rdData[`CSSC_TRACK_HOLD_BIT]    = r.cfg.trackHold;
                    next_r.rdData[`CSSC_SENSE_SELECT_BIT0] = r.cfg.senseSel[0];
                    next_r.rdData[`CSSC_SENSE_SELECT_BIT1] = r.cfg.senseSel[1];
                end
                `CSSC_RETRY_CONFIG_REGISTER0: begin
                    next_r.rdData[`CSSC_OFFSET_POLARITY_BIT] = r.cfg.offsetPos[0];
                end
                `CSSC_RETRY_CONFIG_REGISTER1: begin
                    next_r.rdData[`CSSC_OFFSET_POLARITY_BIT] = r.cfg.offsetPos[1];
                end
                `CSSC_FAULT_REPORT_REGISTER: begin
                    next_r.rdData[`CSSC_PREWARN_BIT] = r.prewarn;
                end
                `CSSC_STATUS_REPORT_REGISTER: begin
                    // Comparator view, not the drive command; low supply may differ
                    next_r.rdData[`CSSC_STATE_CH0_BIT] = r.pinSync.outHigh[0];
                    next_r.rdData[`CSSC_STATE_CH1_BIT] = r.pinSync.outHigh[1];
                end
                `CSSC_IRQ_STATUS_REGISTER: begin
                    next_r.rdData[`CSSC_IRQW-1:0] = r.irqStatus;
                end
                `CSSC_IRQ_MASK_REGISTER: begin
                    next_r.rdData[`CSSC_IRQW-1:0] = r.irqMask;
                end
                default: begin
                    next_r.rdData = '0;
                end
            endcase
        end

        next_r.irq = |(next_r.irqStatus & next_r.irqMask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset values spelled out even where zero, to keep them visible
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r               <= '0;
            r.cfg.trackHold <= `CSSC_TRACK_HOLD_RESET;
            r.cfg.senseSel  <= `CSSC_SENSE_SEL_RESET;
            r.cfg.offsetPos <= `CSSC_OFFSET_POS_RESET;
            r.irqMask       <= `CSSC_IRQ_MASK_RESET;
            r.mode          <= cssc_pkg::CSSC_OFF;
            r.strobeN       <= 1'b1;
            r.senseOut      <= `CSSC_SENSE_ZERO;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Bare flop copies; no logic after the register
    assign rdData               = r.rdData;
    assign senseOut             = r.senseOut;
    assign sense_valid_strobe_n = r.strobeN;
    assign irq                  = r.irq;

endmodule

/* File: test/cssc_top_monitor.sv */
// Purpose: Port-level checks of the sense control block
// Assumes: Outputs move three edges after a pin change
// Notes:   Only ports are watched; config is tracked from bus writes
`timescale 1ns/1ps
`include "cssc_map.svh"

module cssc_top_monitor (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    input  wire logic [31:0] rdData,
    input  wire logic [1:0]  chanOn,
    input  wire logic [1:0]  senseSettled,
    input  wire logic [1:0]  outAboveHalf,
    input  wire logic        blankActive,
    input  wire logic        sense_valid_strobe_n,
    input  wire logic        irq
);
    logic tempSel;
    logic maskZero;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tempSel  <= 1'b0;
            maskZero <= 1'b1;
        end else if (wrStrobe) begin
            if (addr == `CSSC_GENERAL_CONFIG_REGISTER) tempSel <= wrData[1];
            if (addr == `CSSC_IRQ_MASK_REGISTER) maskZero <= (wrData[2:0] == 3'h0);
        end
    end

    // --------------------
    // Checks
    // --------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_strobe_needs_on: assert property (!sense_valid_strobe_n |-> |$past(chanOn, 3))
        else $error("strobe low without a channel on");
    a_strobe_fall_settled: assert property ($fell(sense_valid_strobe_n) |->
        $past(senseSettled, 3) != 2'h0 && !$past(blankActive, 3))
        else $error("strobe fell before settling");
    a_blank_strobe_high: assert property ($past(blankActive, 3) |-> sense_valid_strobe_n)
        else $error("strobe low while blanking");
    a_temp_strobe_high: assert property (tempSel && $past(tempSel, 2) |-> sense_valid_strobe_n)
        else $error("strobe low on temperature source");
    a_read_data_late: assert property (rdData != 32'h0 |-> $past(rdStrobe))
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (rdStrobe && addr == 8'h1c |=> rdData == 32'h0)
        else $error("unmapped read not zero");
    a_fault_word_bits: assert property (rdStrobe && addr == `CSSC_FAULT_REPORT_REGISTER |=>
        rdData[31:9] == 23'h0 && rdData[7:0] == 8'h00)
        else $error("fault word has stray bits");
    a_state_live: assert property (rdStrobe && addr == `CSSC_STATUS_REPORT_REGISTER &&
        $stable(outAboveHalf) && outAboveHalf == $past(outAboveHalf, 2) |=>
        rdData == {30'h0, $past(outAboveHalf)})
        else $error("state bits differ from outputs");
    a_mask_quiet: assert property (maskZero && $past(maskZero, 2) |-> !irq)
        else $error("interrupt with all sources masked");

    c_strobe_valid: cover property ($fell(sense_valid_strobe_n));
    c_irq_rise: cover property ($rose(irq));
    c_prewarn_read: cover property (rdStrobe && addr == 8'h0c ##1 rdData[8]);
endmodule

bind cssc_top cssc_top_monitor i_mon (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .chanOn(chanOn), .senseSettled(senseSettled), .outAboveHalf(outAboveHalf),
    .blankActive(blankActive), .sense_valid_strobe_n(sense_valid_strobe_n), .irq(irq));

/* File: test/cssc_switch_model.sv */
// Purpose: Stand-in for the switch and load behind the channel pins
// Assumes: Output follows the command; sense settles a few cycles later
// Notes:   Fast switching only, so slow-switching hold droop never arises
`timescale 1ns/1ps

module cssc_switch_model #(
    parameter int SETTLE = 2
) (
    input  wire logic       clk,
    input  wire logic [1:0] cmd,
    output logic      [1:0] chanOn,
    output logic      [1:0] settled,
    output logic      [1:0] outHigh
);
    int cnt [2] = '{0, 0};

    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            cnt[i] <= cmd[i] ? cnt[i] + 1 : 0;
        end
    end

    assign chanOn  = cmd;
    assign outHigh = cmd;
    assign settled = {cmd[1] && cnt[1] >= SETTLE, cmd[0] && cnt[0] >= SETTLE};
endmodule

/* File: test/tb_current_sense_status_control.sv */
// Purpose: Scenario bench for the sense control block
// Assumes: Outputs settle three edges after a pin; checks at falling edge
// Notes:   Load 0x200/0x150, offset 0x11, temperature 0xa5
`timescale 1ns/1ps

module tb_current_sense_status_control;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wrData = 32'h0;
    logic        wrStrobe = 1'b0;
    logic        rdStrobe = 1'b0;
    logic [31:0] rdData;
    logic [1:0]  cmd = 2'h0;
    logic [1:0]  chanOn;
    logic [1:0]  settled;
    logic [1:0]  outHigh;
    logic        blank = 1'b0;
    logic        hot = 1'b0;
    logic [9:0]  senseOut;
    logic        strobeN;
    logic        irq;
    logic [31:0] d;
    logic [31:0] a;
    int          failures = 0;
    int          compares = 0;
    int          cycles = 0;

    cssc_switch_model i_sw (.clk(clk), .cmd(cmd), .chanOn(chanOn), .settled(settled),
        .outHigh(outHigh));
    cssc_top i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .chanOn(chanOn),
        .senseSettled(settled), .outAboveHalf(outHigh), .blankActive(blank),
        .tempAbovePrewarn(hot), .loadCode0(10'h200), .loadCode1(10'h150),
        .tempCode(10'h0a5), .offsetCode(6'h11), .senseOut(senseOut),
        .sense_valid_strobe_n(strobeN), .irq(irq));

    initial forever #12.5 clk = ~clk;

    // --------------------
    // Helpers
    // --------------------
    task automatic give_verdict();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge clk);
        addr <= ad;
        wrData <= v;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad);
        @(posedge clk);
        addr <= ad;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        @(negedge clk);
        d = rdData;
    endtask

    task automatic pins(input logic [1:0] c, input int n);
        @(posedge clk);
        cmd <= c;
        cyc(n);
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset();
        chk({31'h0, strobeN}, 32'h1);
        chk({22'h0, senseOut}, 32'h0);
        rd(8'h00);
        chk(d, 32'h0);
        rd(8'h04);
        chk(d, 32'h0);
        rd(8'h18);
        chk(d, 32'h0);
    endtask

    task automatic t_sync();
        pins(2'h1, 8);
        chk({31'h0, strobeN}, 32'h0);
        a = {22'h0, senseOut};
        chk(a, 32'h1ef);
        pins(2'h0, 6);
        chk({31'h0, strobeN}, 32'h1);
        chk({22'h0, senseOut}, 32'h0);
        wr(8'h04, 32'h100);
        pins(2'h1, 8);
        chk({22'h0, senseOut}, 32'h211);
        chk((a + {22'h0, senseOut}) >> 1, 32'h200);
        pins(2'h0, 6);
    endtask

    task automatic t_hold();
        wr(8'h00, 32'h8);
        pins(2'h1, 8);
        // Fifth edge is the one where the store is still loading
        pins(2'h0, 5);
        chk({22'h0, senseOut}, 32'h211);
        cyc(1);
        chk({22'h0, senseOut}, 32'h211);
        chk({31'h0, strobeN}, 32'h1);
        wr(8'h04, 32'h0);
        cyc(6);
        chk({22'h0, senseOut}, 32'h211);
        wr(8'h00, 32'h9);
        cyc(6);
        chk({22'h0, senseOut}, 32'h0);
        pins(2'h2, 8);
        pins(2'h0, 6);
        chk({22'h0, senseOut}, 32'h13f);
        @(posedge clk);
        blank <= 1'b1;
        pins(2'h2, 8);
        chk({31'h0, strobeN}, 32'h1);
        @(posedge clk);
        blank <= 1'b0;
        cyc(6);
        chk({31'h0, strobeN}, 32'h0);
        pins(2'h0, 6);
        wr(8'h00, 32'h2);
        pins(2'h1, 8);
        chk({22'h0, senseOut}, 32'h0a5);
        chk({31'h0, strobeN}, 32'h1);
        pins(2'h0, 6);
    endtask

    task automatic t_warn();
        wr(8'h18, 32'h1);
        @(posedge clk);
        hot <= 1'b1;
        cyc(6);
        rd(8'h0c);
        chk(d, 32'h100);
        rd(8'h0c);
        chk(d, 32'h100);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        hot <= 1'b0;
        cyc(6);
        rd(8'h0c);
        chk(d, 32'h100);
        rd(8'h0c);
        chk(d, 32'h0);
        rd(8'h14);
        chk(d, 32'h7);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        pins(2'h3, 6);
        rd(8'h10);
        chk(d, 32'h3);
        wr(8'h1c, 32'hffff);
        rd(8'h1c);
        chk(d, 32'h0);
        pins(2'h0, 6);
        rd(8'h10);
        chk(d, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        t_reset();
        t_sync();
        t_hold();
        t_warn();
        give_verdict();
    end
endmodule
